/* File: smme_pkg.sv */
// Functional notes
// - Decode opcode 31, extended 467, source bits 6-10
// - Selector is bits 11-20 with halves swapped
// - Valid write stores whole source into selected register
// - Accept only the listed selector values
// - Selector 8 loads the link register
// - Unlisted selector is an invalid form
// - Countdown timer writable only when privileged
// - Register move never touches exception register, field zero
// - Multiply decode: target, first, second factor fields
// - High word to target, low word to low half
// - Four multiply variants from overflow-enable and record bits
// - Multiply never changes the carry bit
// - Overflow-enable sets summary and overflow on overflow
// - Record bit sets sign flags from low word
// - Record bit copies summary overflow into field zero
package smme_pkg;
  // ****************************************************************
  // Instruction fields (bit 31 is the most significant)
  // ****************************************************************
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RD_HI = 25;
  localparam int RD_LO = 21;
  localparam int RA_HI = 20;
  localparam int RA_LO = 16;
  localparam int RB_HI = 15;
  localparam int RB_LO = 11;
  localparam int XO10_HI = 10;
  localparam int XO10_LO = 1;
  localparam int XO9_HI = 9;
  localparam int XO9_LO = 1;
  localparam int OE_POS = 10;
  localparam int RC_POS = 0;
  localparam logic [5:0] OPC_PRIMARY = 6'h1F;
  localparam logic [9:0] XO_MTSPR = 10'h1D3;
  localparam logic [8:0] XO_MUL = 9'h100;
  // ****************************************************************
  // Special registers
  // ****************************************************************
  localparam int SPR_COUNT = 27;
  localparam logic [9:0] SPR_TABLE [SPR_COUNT] = '{
    10'h001, 10'h008, 10'h009, 10'h012, 10'h013, 10'h016, 10'h019, 10'h01A, 10'h01B,
    10'h110, 10'h112, 10'h113, 10'h11A, 10'h11C, 10'h11D,
    10'h210, 10'h211, 10'h212, 10'h213, 10'h214, 10'h215, 10'h216, 10'h217, 10'h218,
    10'h219, 10'h21A, 10'h21B};
  localparam logic [9:0] SPR_LINK = 10'h008;
  localparam logic [9:0] SPR_DEC = 10'h016;
  localparam logic [31:0] SPR_RST = 32'h0000_0000;
  // ****************************************************************
  // Exception register and condition field zero
  // ****************************************************************
  localparam int XER_SO = 31;
  localparam int XER_OV = 30;
  localparam int XER_CA = 29;
  localparam logic [31:0] XER_RST = 32'h0000_0000;
  localparam int CR_LT = 3;
  localparam int CR_GT = 2;
  localparam int CR_EQ = 1;
  localparam int CR_SO = 0;
  localparam logic [3:0] CR_RST = 4'h0;
  // ****************************************************************
  // Avalon register map (word addresses)
  // ****************************************************************
  localparam int AW = 6;
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_MASK = 6'h01;
  localparam logic [5:0] ADDR_XER = 6'h02;
  localparam logic [5:0] ADDR_CR0 = 6'h03;
  localparam logic [5:0] ADDR_LOW = 6'h04;
  localparam logic [5:0] ADDR_LAST_SEL = 6'h05;
  localparam logic [5:0] ADDR_BANK = 6'h20;
  localparam int EV_SPR = 0;
  localparam int EV_MUL = 1;
  localparam int EV_EXC = 2;
  localparam int EV_OVF = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_RST = 4'h0;
  typedef enum logic [1:0] {SMME_EXC_SEL, SMME_EXC_PRIV, SMME_EXC_OP} smme_exc_t;
endpackage : smme_pkg

/* File: smme_mul_if.sv */
`timescale 1ns/1ps
interface smme_mul_if;
  logic start;
  logic signed [31:0] a;
  logic signed [31:0] b;
  logic valid;
  logic signed [63:0] product;
  logic ovf;
  modport core(output start, output a, output b, input valid, input product, input ovf);
  modport unit(input start, input a, input b, output valid, output product, output ovf);
endinterface : smme_mul_if

/* File: smme_mul.sv */
`timescale 1ns/1ps
module smme_mul (
  input wire logic i_clk,
  input wire logic i_reset_n,
  smme_mul_if.unit mul
);
  logic signed [63:0] prod_c;
  logic ovf_c;

  assign prod_c = mul.a * mul.b;
  assign ovf_c = (prod_c[63:32] != {32{prod_c[31]}});

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mul.valid <= 1'b0;
      mul.product <= 64'h0000_0000_0000_0000;
      mul.ovf <= 1'b0;
    end else begin
      mul.valid <= mul.start;
      if (mul.start) begin
        mul.product <= prod_c;
        mul.ovf <= ovf_c;
      end
    end
  end

  AST_MUL_SIGNED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    mul.start && mul.a[31] && !mul.b[31] && (mul.b != 32'h0000_0000)
    |=> mul.valid && mul.product[63])
    else $error("negative times positive gave non-negative product");

  AST_MUL_OVF_FLAG: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    mul.start |=> mul.valid && (mul.ovf == (mul.product[63:32] != {32{mul.product[31]}})))
    else $error("overflow flag disagrees with product");
endmodule : smme_mul

/* File: smme_exec.sv */
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module smme_exec (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_issue,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_src_val,
  input wire logic [31:0] i_first_val,
  input wire logic [31:0] i_second_val,
  input wire logic i_privileged,
  output logic o_ready,
  output logic o_done,
  output logic o_exception,
  output smme_pkg::smme_exc_t o_exc_cause,
  output logic o_gpr_we,
  output logic [4:0] o_gpr_idx,
  output logic [31:0] o_gpr_data,
  output logic [31:0] o_low_half,
  output logic [31:0] o_xer,
  output logic [3:0] o_cr0,
  output logic [31:0] o_link,
  output logic o_irq,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function automatic logic [5:0] spr_lookup(input logic [9:0] sel);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < smme_pkg::SPR_COUNT; i++) begin
      if (sel == smme_pkg::SPR_TABLE[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : spr_lookup

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic is_primary(input logic [31:0] ins);
    return ins[smme_pkg::OPC_HI:smme_pkg::OPC_LO] == smme_pkg::OPC_PRIMARY;
  endfunction : is_primary

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  logic is_mtspr;
  logic is_mul;
  logic [9:0] sel;
  logic [5:0] sel_hit_idx;
  logic sel_hit;
  logic [4:0] sel_idx;
  logic is_dec;
  logic accept;
  logic spr_ok;
  logic exc_sel;
  logic exc_priv;
  logic exc_op;
  logic mul_start;

  assign is_mtspr = is_primary(i_instr) &&
                    (i_instr[smme_pkg::XO10_HI:smme_pkg::XO10_LO] == smme_pkg::XO_MTSPR);
  assign is_mul = is_primary(i_instr) &&
                  (i_instr[smme_pkg::XO9_HI:smme_pkg::XO9_LO] == smme_pkg::XO_MUL);
  assign sel = {i_instr[smme_pkg::RB_HI:smme_pkg::RB_LO],
                i_instr[smme_pkg::RA_HI:smme_pkg::RA_LO]};
  assign sel_hit_idx = spr_lookup(sel);
  assign sel_hit = sel_hit_idx[5];
  assign sel_idx = sel_hit_idx[4:0];
  assign is_dec = (sel == smme_pkg::SPR_DEC);
  assign accept = i_issue && o_ready;
  assign spr_ok = accept && is_mtspr && sel_hit && !(is_dec && !i_privileged);
  assign exc_sel = accept && is_mtspr && !sel_hit;
  assign exc_priv = accept && is_mtspr && sel_hit && is_dec && !i_privileged;
  assign exc_op = accept && !is_mtspr && !is_mul;
  assign mul_start = accept && is_mul;

  // ****************************************************************
  // Multiplier
  // ****************************************************************
  smme_mul_if mul_bus ();
  logic [4:0] mul_rt;
  logic mul_oe;
  logic mul_rc;
  logic so_next;
  logic [31:0] prod_lo;

  assign mul_bus.start = mul_start;
  assign mul_bus.a = i_first_val;
  assign mul_bus.b = i_second_val;
  assign prod_lo = mul_bus.product[31:0];
  assign so_next = o_xer[smme_pkg::XER_SO] | (mul_oe & mul_bus.ovf);

  smme_mul u_mul (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .mul(mul_bus.unit)
  );

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mul_rt <= 5'h00;
      mul_oe <= 1'b0;
      mul_rc <= 1'b0;
    end else if (mul_start) begin
      mul_rt <= i_instr[smme_pkg::RD_HI:smme_pkg::RD_LO];
      mul_oe <= i_instr[smme_pkg::OE_POS];
      mul_rc <= i_instr[smme_pkg::RC_POS];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_ready <= 1'b1;
    end else if (mul_start) begin
      o_ready <= 1'b0;
    end else if (mul_bus.valid) begin
      o_ready <= 1'b1;
    end
  end

  // ****************************************************************
  // Completion and write-back
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_gpr_we <= 1'b0;
      o_gpr_idx <= 5'h00;
      o_gpr_data <= 32'h0000_0000;
    end else begin
      o_gpr_we <= mul_bus.valid;
      if (mul_bus.valid) begin
        o_gpr_idx <= mul_rt;
        o_gpr_data <= mul_bus.product[63:32];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
      o_exception <= 1'b0;
      o_exc_cause <= smme_pkg::SMME_EXC_SEL;
    end else begin
      o_done <= mul_bus.valid || (accept && !is_mul);
      o_exception <= exc_sel || exc_priv || exc_op;
      if (exc_sel) begin
        o_exc_cause <= smme_pkg::SMME_EXC_SEL;
      end else if (exc_priv) begin
        o_exc_cause <= smme_pkg::SMME_EXC_PRIV;
      end else if (exc_op) begin
        o_exc_cause <= smme_pkg::SMME_EXC_OP;
      end
    end
  end

  // ****************************************************************
  // Special register bank
  // ****************************************************************
  logic [31:0] spr_bank [smme_pkg::SPR_COUNT];
  logic [9:0] last_sel;

  for (genvar g = 0; g < smme_pkg::SPR_COUNT; g++) begin : g_bank
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        spr_bank[g] <= smme_pkg::SPR_RST;
      end else if (spr_ok && (sel_idx == 5'(g))) begin
        spr_bank[g] <= i_src_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_link <= smme_pkg::SPR_RST;
      last_sel <= 10'h000;
    end else begin
      if (spr_ok && (sel == smme_pkg::SPR_LINK)) begin
        o_link <= i_src_val;
      end
      if (accept && is_mtspr) begin
        last_sel <= sel;
      end
    end
  end

  // ****************************************************************
  // Avalon slave
  // ****************************************************************
  logic wr_en;
  logic [5:0] bank_off;
  logic [31:0] rd_value;
  logic [3:0] status;
  logic [3:0] mask;

  assign wr_en = i_avs_write && !o_avs_waitrequest;
  assign bank_off = i_avs_address - smme_pkg::ADDR_BANK;

  always_comb begin
    rd_value = 32'h0000_0000;
    case (i_avs_address)
      smme_pkg::ADDR_STATUS: rd_value = {28'h000_0000, status};
      smme_pkg::ADDR_MASK: rd_value = {28'h000_0000, mask};
      smme_pkg::ADDR_XER: rd_value = o_xer;
      smme_pkg::ADDR_CR0: rd_value = {28'h000_0000, o_cr0};
      smme_pkg::ADDR_LOW: rd_value = o_low_half;
      smme_pkg::ADDR_LAST_SEL: rd_value = {22'h00_0000, last_sel};
      default: begin
        if ((i_avs_address >= smme_pkg::ADDR_BANK) &&
            (bank_off < 6'(smme_pkg::SPR_COUNT))) begin
          rd_value = spr_bank[bank_off[4:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_value;
      end
    end
  end

  // ****************************************************************
  // Exception register, field zero, low half
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_xer <= smme_pkg::XER_RST;
    end else begin
      if (wr_en && (i_avs_address == smme_pkg::ADDR_XER)) begin
        o_xer <= be_merge(o_xer, i_avs_writedata, i_avs_byteenable);
      end
      if (mul_bus.valid && mul_oe) begin
        o_xer[smme_pkg::XER_OV] <= mul_bus.ovf;
        if (mul_bus.ovf) begin
          o_xer[smme_pkg::XER_SO] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_cr0 <= smme_pkg::CR_RST;
    end else begin
      if (wr_en && (i_avs_address == smme_pkg::ADDR_CR0) && i_avs_byteenable[0]) begin
        o_cr0 <= i_avs_writedata[3:0];
      end
      if (mul_bus.valid && mul_rc) begin
        o_cr0[smme_pkg::CR_LT] <= prod_lo[31];
        o_cr0[smme_pkg::CR_GT] <= !prod_lo[31] && (prod_lo != 32'h0000_0000);
        o_cr0[smme_pkg::CR_EQ] <= (prod_lo == 32'h0000_0000);
        o_cr0[smme_pkg::CR_SO] <= so_next;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_low_half <= 32'h0000_0000;
    end else if (mul_bus.valid) begin
      o_low_half <= prod_lo;
    end else if (wr_en && (i_avs_address == smme_pkg::ADDR_LOW)) begin
      o_low_half <= be_merge(o_low_half, i_avs_writedata, i_avs_byteenable);
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [3:0] events;
  logic [3:0] next_status;
  logic [3:0] next_mask;

  assign events = {mul_bus.valid && mul_oe && mul_bus.ovf,
                   exc_sel || exc_priv || exc_op,
                   mul_bus.valid,
                   spr_ok};

  always_comb begin
    next_status = status;
    next_mask = mask;
    if (wr_en && (i_avs_address == smme_pkg::ADDR_STATUS) && i_avs_byteenable[0]) begin
      next_status = status & ~i_avs_writedata[3:0];
    end
    if (wr_en && (i_avs_address == smme_pkg::ADDR_MASK) && i_avs_byteenable[0]) begin
      next_mask = i_avs_writedata[3:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status <= smme_pkg::EV_RST;
      mask <= smme_pkg::EV_RST;
      o_irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      o_irq <= |(next_status & next_mask);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic signed [63:0] chk_prod;
  assign chk_prod = $signed(i_first_val) * $signed(i_second_val);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_mul_issue;
    accept && is_mul;
  endsequence

  sequence s_mul_commit;
    mul_bus.valid && !i_avs_write;
  endsequence

  AST_LINK_LOAD: assert property (spr_ok && (sel == smme_pkg::SPR_LINK)
    |=> (o_link == $past(i_src_val)) && o_done && !o_exception)
    else $error("link register not loaded");

  AST_SWAP_DEC: assert property (accept && is_mtspr && (i_instr[20:16] == 5'h16) &&
    (i_instr[15:11] == 5'h00) && !i_privileged
    |=> o_exception && (o_exc_cause == smme_pkg::SMME_EXC_PRIV))
    else $error("unprivileged countdown write not refused");

  AST_BAD_SEL: assert property (accept && is_mtspr && !sel_hit
    |=> o_exception && (o_exc_cause == smme_pkg::SMME_EXC_SEL) && !o_gpr_we)
    else $error("bad selector not flagged");

  AST_MOVE_KEEPS_FLAGS: assert property (accept && is_mtspr && !i_avs_write
    |=> $stable(o_xer) && $stable(o_cr0))
    else $error("register move changed flags");

  AST_MUL_WB: assert property (s_mul_issue ##1 mul_bus.valid
    |=> o_gpr_we && ({o_gpr_data, o_low_half} == $past(chk_prod, 2)))
    else $error("multiply write-back wrong");

  AST_READY_GAP: assert property (s_mul_issue |=> !o_ready ##1 o_ready)
    else $error("ready not restored after multiply");

  AST_CARRY_KEPT: assert property (s_mul_commit
    |=> o_xer[smme_pkg::XER_CA] == $past(o_xer[smme_pkg::XER_CA]))
    else $error("multiply changed carry");

  AST_OVF_SET: assert property (s_mul_commit and (mul_oe && mul_bus.ovf)
    |=> o_xer[smme_pkg::XER_SO] && o_xer[smme_pkg::XER_OV])
    else $error("overflow bits not set");

  AST_CR0_SIGN: assert property (s_mul_commit and mul_rc
    |=> (o_cr0[smme_pkg::CR_EQ] == (o_low_half == 32'h0000_0000)) &&
        (o_cr0[smme_pkg::CR_LT] == o_low_half[31]))
    else $error("field zero sign flags wrong");

  AST_CR0_SO: assert property (s_mul_commit and mul_rc
    |=> o_cr0[smme_pkg::CR_SO] == o_xer[smme_pkg::XER_SO])
    else $error("summary overflow not copied");

  AST_BUS_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
endmodule : smme_exec

/* File: smme_gpr_model.sv */
`timescale 1ns/1ps
module smme_gpr_model (
  input wire logic i_clk,
  input wire logic [31:0] i_instr,
  input wire logic i_gpr_we,
  input wire logic [4:0] i_gpr_idx,
  input wire logic [31:0] i_gpr_data,
  output logic [31:0] o_src_val,
  output logic [31:0] o_first_val,
  output logic [31:0] o_second_val
);
  // ****************************************************************
  // Register file beyond the execution block
  // ****************************************************************
  logic [31:0] gpr [32];
  initial begin
    for (int i = 0; i < 32; i++) begin
      gpr[i] = 32'h0101_0101 * i;
    end
  end
  always @(posedge i_clk) begin
    if (i_gpr_we) begin
      gpr[i_gpr_idx] <= i_gpr_data;
    end
  end
  assign o_src_val = gpr[i_instr[25:21]];
  assign o_first_val = gpr[i_instr[20:16]];
  assign o_second_val = gpr[i_instr[15:11]];
endmodule : smme_gpr_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  logic i_clk, i_reset_n, i_issue, i_privileged, i_avs_read, i_avs_write;
  logic [31:0] i_instr, i_avs_writedata, rd, x, ex, l0;
  logic [5:0] i_avs_address;
  logic [3:0] ec;
  logic signed [63:0] p;
  logic ov;
  logic [31:0] src, fa, fb, gd, lo, fixed_point_exception_reg, link, rdata;
  logic rdy, done, exc, we, irq, wq;
  logic [4:0] gidx;
  logic [3:0] cr0;
  smme_pkg::smme_exc_t cause;
  int err_total, samples_checked;
  logic [31:0] ma [6] = '{32'h3, 32'h4500, 32'h4500, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFE};
  logic [31:0] mb [6] = '{32'h2, 32'h8000_7000, 32'h8000_7000, 32'hFFFF_FFFF, 32'h5, 32'h3};
  logic [1:0] mf [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [9:0] gs [4] = '{10'h001, 10'h110, 10'h21B, 10'h016};
  logic [5:0] ga [4] = '{6'h20, 6'h29, 6'h3A, 6'h25};
  logic [9:0] bs [4] = '{10'h000, 10'h002, 10'h21C, 10'h3FF};
  smme_exec i_smme_exec (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_issue(i_issue),
    .i_instr(i_instr), .i_src_val(src), .i_first_val(fa), .i_second_val(fb),
    .i_privileged(i_privileged), .o_ready(rdy), .o_done(done), .o_exception(exc),
    .o_exc_cause(cause), .o_gpr_we(we), .o_gpr_idx(gidx), .o_gpr_data(gd),
    .o_low_half(lo), .o_xer(fixed_point_exception_reg), .o_cr0(cr0), .o_link(link), .o_irq(irq),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq));
  smme_gpr_model i_smme_gpr_model (.i_clk(i_clk), .i_instr(i_instr), .i_gpr_we(we),
    .i_gpr_idx(gidx), .i_gpr_data(gd), .o_src_val(src), .o_first_val(fa),
    .o_second_val(fb));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] mv(input logic [9:0] s, input logic [4:0] r);
    return {6'h1F, r, s[4:0], s[9:5], 10'h1D3, 1'b0};
  endfunction : mv
  task chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin @(posedge i_clk); end while (wq !== 1'b0);
    rd = rdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask : bus
  task run(input logic [31:0] ins, input logic pv);
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_instr <= ins;
    i_privileged <= pv;
    do begin @(posedge i_clk); end while (rdy !== 1'b1);
    i_issue <= 1'b0;
    do begin @(posedge i_clk); end while (done !== 1'b1);
    x = {31'h0, exc};
  endtask : run
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    {i_reset_n, i_issue, i_privileged, i_avs_read, i_avs_write} = '0;
    {i_instr, i_avs_writedata, i_avs_address, err_total, samples_checked} = '0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk({rdy, wq, fixed_point_exception_reg, cr0, link, lo}, {2'h3, 100'h0});
    bus(1'b1, smme_pkg::ADDR_XER, 32'h2000_0000);
    ex = 32'h2000_0000;
    ec = 4'h0;
    for (int i = 0; i < 6; i++) begin
      i_smme_gpr_model.gpr[4] = ma[i];
      i_smme_gpr_model.gpr[10] = mb[i];
      run({6'h1F, 15'h188A, mf[i][1], 9'h100, mf[i][0]}, 1'b0);
      p = $signed(ma[i]) * $signed(mb[i]);
      ov = p[63:32] != {32{p[31]}};
      if (mf[i][1]) begin
        ex[30] = ov;
        ex[31] = ex[31] | ov;
      end
      if (mf[i][0]) begin
        ec = {p[31], !p[31] && p[31:0] != 0, p[31:0] == 0, ex[31]};
      end
      chk({x, gidx, gd, lo}, {32'h0, 5'd6, p});
      chk(fixed_point_exception_reg, ex);
      chk(cr0, ec);
    end
    $display("multiply table done");
    i_smme_gpr_model.gpr[5] = 32'hCAFE_0001;
    run(mv(10'h008, 5'd5), 1'b0);
    chk({x, link}, {32'h0, 32'hCAFE_0001});
    chk({fixed_point_exception_reg, cr0}, {ex, ec});
    for (int i = 0; i < 4; i++) begin
      i_smme_gpr_model.gpr[7] = 32'hA5A5_0000 + i;
      run(mv(gs[i], 5'd7), 1'b1);
      bus(1'b0, ga[i], 32'h0);
      chk({x, rd}, {32'h0, 32'hA5A5_0000 + i});
    end
    for (int i = 0; i < 4; i++) begin
      run(mv(bs[i], 5'd7), 1'b1);
      chk({x, cause, link}, {32'h1, smme_pkg::SMME_EXC_SEL, 32'hCAFE_0001});
    end
    run(mv(10'h016, 5'd5), 1'b0);
    bus(1'b0, 6'h25, 32'h0);
    chk({x, cause, rd}, {32'h1, smme_pkg::SMME_EXC_PRIV, 32'hA5A5_0003});
    run(32'h0, 1'b1);
    chk({x, cause}, {32'h1, smme_pkg::SMME_EXC_OP});
    chk({fixed_point_exception_reg, cr0}, {ex, ec});
    $display("move tests done");
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_instr <= mv(10'h008, 5'd4);
    @(posedge i_clk);
    i_instr <= mv(10'h008, 5'd6);
    @(posedge i_clk);
    i_issue <= 1'b0;
    l0 = link;
    @(posedge i_clk);
    chk({l0, link}, {32'hFFFF_FFFE, i_smme_gpr_model.gpr[6]});
    bus(1'b1, 6'h25, 32'h0);
    bus(1'b0, 6'h25, 32'h0);
    chk(rd, 32'hA5A5_0003);
    bus(1'b0, 6'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, smme_pkg::ADDR_LAST_SEL, 32'h0);
    chk(rd, 32'h0000_0008);
    bus(1'b1, smme_pkg::ADDR_MASK, 32'h0);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    bus(1'b1, smme_pkg::ADDR_MASK, 32'h4);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b1);
    bus(1'b1, smme_pkg::ADDR_STATUS, 32'hF);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    bus(1'b0, smme_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("bus and interrupt tests done");
    end_of_test();
  end
endmodule : tb
